// ---- design/sdcf_flags.sv ----
/*
 Two 256 x 36 queues (A to B, B to A) with pointer tracking, offset
 registers, output-register prefetch and four flags per queue.
 Assumes port clocks arrive as one-cycle enables synchronous to clk.
*/
// Notes on behaviour
// - Flags pass two synchroniser stages minimum
// - Each port's flags advance on its tick
// - Word in output register frees its slot
// - Output-ready low holds word, ignores reads
// - Read pointer advances per loaded word
// - Output-ready sees empty, +1, +2 states
// - Write reaches output on third read edge
// - Late-sampled write may take one edge more
// - Input-ready low when full, writes ignored
// - Write pointer advances per accepted word
// - Input-ready sees full, -1, -2 states
// - Input-ready rises on second write edge
// - Late-sampled read may take one edge more
// - Almost-empty low at or below offset
// - Empty offsets preset at reset or programmed
// - Almost-empty rises on second read edge
// - Almost-empty first cycle needs skew margin
// - A-to-B queue uses its own offsets
// - B-to-A queue mirrors with own offsets
// - Almost-full rises on second write edge
// - Empty output register loads automatically
`timescale 1ns/100ps
module sdcf_flags (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic                        port_a_clock,
    input  wire logic                        port_b_clock,
    input  wire logic [1:0]                  flag_select,
    input  wire logic                        ab_wr_en,
    input  wire logic [sdcf_pkg::DATA_W-1:0] ab_wr_data,
    input  wire logic                        ab_rd_en,
    output logic      [sdcf_pkg::DATA_W-1:0] ab_rd_data,
    input  wire logic                        ba_wr_en,
    input  wire logic [sdcf_pkg::DATA_W-1:0] ba_wr_data,
    input  wire logic                        ba_rd_en,
    output logic      [sdcf_pkg::DATA_W-1:0] ba_rd_data,
    input  wire logic                        ofs_wr_en,
    input  wire logic [1:0]                  ofs_sel,
    input  wire logic [sdcf_pkg::OFS_W-1:0]  ofs_data,
    output logic                             port_a_in_ready,
    output logic                             port_a_almost_full_n,
    output logic                             port_a_out_ready,
    output logic                             port_a_almost_empty_n,
    output logic                             port_b_in_ready,
    output logic                             port_b_almost_full_n,
    output logic                             port_b_out_ready,
    output logic                             port_b_almost_empty_n
);
    import sdcf_pkg::*;

    typedef struct packed {
        logic [1:0][PTR_W-1:0] wptr;   // Binary write pointer
        logic [1:0][PTR_W-1:0] wgray;  // Gray copy sent to reader side
        logic [1:0][PTR_W-1:0] rptr;   // Binary read pointer
        logic [1:0][PTR_W-1:0] rgray;  // Gray copy sent to writer side
        logic [1:0][PTR_W-1:0] rs1;    // Reader-side first stage
        logic [1:0][PTR_W-1:0] rs2;    // Reader-side second stage
        logic [1:0][PTR_W-1:0] ws1;    // Writer-side first stage
        logic [1:0][PTR_W-1:0] ws2;    // Writer-side second stage
        logic [1:0]            ordy;
        logic [1:0]            aen;
        logic [1:0]            irdy;
        logic [1:0]            afn;
        logic [1:0][OFS_W-1:0] xofs;   // Almost-empty offsets
        logic [1:0][OFS_W-1:0] yofs;   // Almost-full offsets
    } sdcf_state_s;

    sdcf_state_s state_reg;
    sdcf_state_s state_next;
    logic [1:0]  wr_tick;
    logic [1:0]  rd_tick;
    logic [1:0]  wr_req;
    logic [1:0]  rd_req;
    logic [1:0]  wr_ok;
    logic [1:0]  load;

    function automatic sdcf_ptr_t bin2gray(input sdcf_ptr_t b);
        return b ^ (b >> 1);
    endfunction

    function automatic sdcf_ptr_t gray2bin(input sdcf_ptr_t g);
        sdcf_ptr_t b;
        b = g;
        for (int i = PTR_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    function automatic logic [OFS_W-1:0] preset(input logic [1:0] fs);
        logic [OFS_W-1:0] v;
        unique case (fs)
            FS_PRE64: v = OFS_PRE64;
            FS_PRE16: v = OFS_PRE16;
            FS_PRE8:  v = OFS_PRE8;
            FS_PROGRAM: v = OFS_PROG_RST;
        endcase
        return v;
    endfunction

    // Queue 0 is written on port A, read on port B; queue 1 the reverse
    assign wr_tick = {port_b_clock, port_a_clock};
    assign rd_tick = {port_a_clock, port_b_clock};
    assign wr_req  = {ba_wr_en, ab_wr_en};
    assign rd_req  = {ba_rd_en, ab_rd_en};

    // Next-state for both queues
    always_comb begin
        sdcf_ptr_t fill_w;
        sdcf_ptr_t avail;
        fill_w     = '0;
        avail      = '0;
        state_next = state_reg;
        wr_ok      = '0;
        load       = '0;
        for (int q = 0; q < 2; q++) begin
            // Writer side
            if (wr_tick[q]) begin
                wr_ok[q] = wr_req[q] && state_reg.irdy[q];
                if (wr_ok[q]) begin
                    state_next.wptr[q] = state_reg.wptr[q] + 9'h001;
                end
                state_next.wgray[q] = bin2gray(state_next.wptr[q]);
                state_next.ws1[q]   = state_reg.rgray[q];
                state_next.ws2[q]   = state_reg.ws1[q];
                fill_w = state_next.wptr[q] - gray2bin(state_next.ws2[q]);
                state_next.irdy[q] = (fill_w != DEPTH_WORDS);
                state_next.afn[q]  = (fill_w < (DEPTH_WORDS - {1'b0, state_reg.yofs[q]}));
            end
            // Reader side; load decision uses the second stage only
            if (rd_tick[q]) begin
                avail = gray2bin(state_reg.rs2[q]) - state_reg.rptr[q];
                load[q] = (avail != 9'h000) && (!state_reg.ordy[q] || rd_req[q]);
                if (load[q]) begin
                    state_next.rptr[q] = state_reg.rptr[q] + 9'h001;
                    state_next.ordy[q] = 1'b1;
                end else if (rd_req[q]) begin
                    state_next.ordy[q] = 1'b0;                            // Last word consumed
                end
                state_next.rgray[q] = bin2gray(state_next.rptr[q]);
                state_next.rs1[q]   = state_reg.wgray[q];
                state_next.rs2[q]   = state_reg.rs1[q];
                avail = gray2bin(state_next.rs2[q]) - state_next.rptr[q];
                state_next.aen[q] = (avail > {1'b0, state_reg.xofs[q]});
            end
        end
        // Offsets written from port A into the register chosen by ofs_sel
        if (port_a_clock && ofs_wr_en) begin
            unique case (ofs_sel)
                SEL_AB_FULL:  state_next.yofs[Q_AB] = ofs_data;
                SEL_AB_EMPTY: state_next.xofs[Q_AB] = ofs_data;
                SEL_BA_FULL:  state_next.yofs[Q_BA] = ofs_data;
                SEL_BA_EMPTY: state_next.xofs[Q_BA] = ofs_data;
            endcase
        end
    end

    // Register; the flag select is caught as a strap while reset is held
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg      <= '0;
            state_reg.irdy <= 2'h3;
            state_reg.afn  <= 2'h3;
            state_reg.xofs <= {preset(flag_select), preset(flag_select)};
            state_reg.yofs <= {preset(flag_select), preset(flag_select)};
        end else begin
            state_reg <= state_next;
        end
    end

    // Word stores; their read registers are the output registers
    sdcf_mem #(.WIDTH(DATA_W), .AW(ADDR_W)) u_mem_ab (
        .clk     (clk),
        .wr_en   (wr_ok[Q_AB]),
        .wr_addr (state_reg.wptr[Q_AB][ADDR_W-1:0]),
        .wr_data (ab_wr_data),
        .rd_en   (load[Q_AB]),
        .rd_addr (state_reg.rptr[Q_AB][ADDR_W-1:0]),
        .rd_data (ab_rd_data)
    );

    sdcf_mem #(.WIDTH(DATA_W), .AW(ADDR_W)) u_mem_ba (
        .clk     (clk),
        .wr_en   (wr_ok[Q_BA]),
        .wr_addr (state_reg.wptr[Q_BA][ADDR_W-1:0]),
        .wr_data (ba_wr_data),
        .rd_en   (load[Q_BA]),
        .rd_addr (state_reg.rptr[Q_BA][ADDR_W-1:0]),
        .rd_data (ba_rd_data)
    );

    // Port flags straight from state flip-flops
    assign port_a_in_ready       = state_reg.irdy[Q_AB];
    assign port_a_almost_full_n  = state_reg.afn[Q_AB];
    assign port_a_out_ready      = state_reg.ordy[Q_BA];
    assign port_a_almost_empty_n = state_reg.aen[Q_BA];
    assign port_b_in_ready       = state_reg.irdy[Q_BA];
    assign port_b_almost_full_n  = state_reg.afn[Q_BA];
    assign port_b_out_ready      = state_reg.ordy[Q_AB];
    assign port_b_almost_empty_n = state_reg.aen[Q_AB];

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_full_write_ignored: assert property (
        port_a_clock && ab_wr_en && !port_a_in_ready |=> $stable(state_reg.wptr[Q_AB]))
        else $error("write accepted while queue full");
    a_write_ptr_step: assert property (
        wr_ok[Q_BA] |=> state_reg.wptr[Q_BA] == $past(state_reg.wptr[Q_BA]) + 9'h001)
        else $error("write pointer did not step by one");
    a_read_ptr_load: assert property (
        load[Q_AB] |=> (state_reg.rptr[Q_AB] == $past(state_reg.rptr[Q_AB]) + 9'h001) && port_b_out_ready)
        else $error("load did not step read pointer and raise ready");
    a_hold_when_low: assert property (
        port_b_clock && !port_b_out_ready && !load[Q_AB] |=> $stable(ab_rd_data))
        else $error("output word changed while not ready");
    a_ready_rise_load: assert property (
        $rose(port_a_out_ready) |-> $past(load[Q_BA]))
        else $error("output ready rose without a load");
    a_sync_two_stage: assert property (
        port_b_clock |=> state_reg.rs2[Q_AB] == $past(state_reg.rs1[Q_AB]))
        else $error("second synchroniser stage skipped");
    a_gray_one_bit: assert property (
        $onehot0(state_reg.wgray[Q_AB] ^ $past(state_reg.wgray[Q_AB])))
        else $error("gray pointer changed more than one bit");
    a_in_ready_full: assert property (
        port_a_in_ready |-> (state_reg.wptr[Q_AB] - gray2bin(state_reg.ws2[Q_AB])) != DEPTH_WORDS)
        else $error("input ready high with queue full");
    a_almost_empty_lvl: assert property (
        port_b_almost_empty_n |->
            (gray2bin(state_reg.rs2[Q_AB]) - state_reg.rptr[Q_AB]) > {1'b0, state_reg.xofs[Q_AB]})
        else $error("almost-empty high at or below offset");
    a_almost_full_lvl: assert property (
        !port_a_almost_full_n |->
            (state_reg.wptr[Q_AB] - gray2bin(state_reg.ws2[Q_AB]))
                >= (DEPTH_WORDS - {1'b0, state_reg.yofs[Q_AB]}))
        else $error("almost-full low below threshold");
    a_empty_write_lat: assert property (
        port_a_clock && wr_ok[Q_AB] && !port_b_out_ready && state_reg.rptr[Q_AB] == state_reg.wptr[Q_AB]
        ##1 !port_b_clock [*2] |=> !port_b_out_ready)
        else $error("word reached output too early");

    // Mirror checks for the B-to-A queue
    a_ba_full_ignored: assert property (
        port_b_clock && ba_wr_en && !port_b_in_ready |=> $stable(state_reg.wptr[Q_BA]))
        else $error("write accepted while return queue full");
    a_ba_not_full: assert property (
        port_b_in_ready |-> (state_reg.wptr[Q_BA] - gray2bin(state_reg.ws2[Q_BA])) != DEPTH_WORDS)
        else $error("return queue input ready high while full");
    a_ba_ptr_load: assert property (
        load[Q_BA] |=> (state_reg.rptr[Q_BA] == $past(state_reg.rptr[Q_BA]) + 9'h001) && port_a_out_ready)
        else $error("return load did not step read pointer");

    // Reads with nothing to show are dropped; a visible word loads unasked
    a_low_read_ignored: assert property (
        port_b_clock && ab_rd_en && !port_b_out_ready
            && gray2bin(state_reg.rs2[Q_AB]) == state_reg.rptr[Q_AB]
        |=> $stable(state_reg.rptr[Q_AB]) && !port_b_out_ready)
        else $error("read taken while output not ready");
    a_auto_load: assert property (
        port_b_clock && !port_b_out_ready && gray2bin(state_reg.rs2[Q_AB]) != state_reg.rptr[Q_AB]
        |=> port_b_out_ready)
        else $error("visible word not loaded automatically");
    a_ba_auto_load: assert property (
        port_a_clock && !port_a_out_ready && gray2bin(state_reg.rs2[Q_BA]) != state_reg.rptr[Q_BA]
        |=> port_a_out_ready)
        else $error("visible return word not loaded automatically");
    a_ready_fall_read: assert property (
        $fell(port_b_out_ready) |-> $past(port_b_clock) && $past(ab_rd_en))
        else $error("output ready fell without a read");
    a_ba_ready_fall: assert property (
        $fell(port_a_out_ready) |-> $past(port_a_clock) && $past(ba_rd_en))
        else $error("return output ready fell without a read");

    // Flags of one port move only on that port's tick
    a_port_a_flags: assert property (
        !port_a_clock
        |=> $stable({port_a_in_ready, port_a_almost_full_n, port_a_out_ready, port_a_almost_empty_n}))
        else $error("port A flag moved without its tick");
    a_port_b_flags: assert property (
        !port_b_clock
        |=> $stable({port_b_in_ready, port_b_almost_full_n, port_b_out_ready, port_b_almost_empty_n}))
        else $error("port B flag moved without its tick");

    // A full queue only reopens once the second stage has seen the read
    a_in_ready_rise: assert property (
        $rose(port_a_in_ready) |-> $changed(state_reg.ws2[Q_AB]))
        else $error("input ready rose before the read was synchronised");
    a_ba_room_rise: assert property (
        $rose(port_b_in_ready) |-> $changed(state_reg.ws2[Q_BA]))
        else $error("return input ready rose before the read was synchronised");

    c_queue_full:   cover property (!port_a_in_ready);
    c_ready_rise:   cover property ($rose(port_b_out_ready));
    c_ae_rise:      cover property ($rose(port_a_almost_empty_n));
    c_af_fall:      cover property ($fell(port_b_almost_full_n));
    c_ba_ready_rise: cover property ($rose(port_a_out_ready));
endmodule // sdcf_flags

// ---- design/sdcf_mem.sv ----
/*
 Simple dual-port word store with a registered read port.
 Assumes one clock; read data hold until the next read enable.
*/
`timescale 1ns/100ps
module sdcf_mem #(
    parameter int WIDTH = 36,
    parameter int AW    = 8
) (
    input  wire logic             clk,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             rd_en,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] store [0:(1<<AW)-1];

    // Write port
    always_ff @(posedge clk) begin
        if (wr_en) begin
            store[wr_addr] <= wr_data;
        end
    end

    // Read register doubles as the queue output register
    always_ff @(posedge clk) begin
        if (rd_en) begin
            rd_data <= store[rd_addr];
        end
    end
endmodule // sdcf_mem

// ---- design/sdcf_pkg.sv ----
/*
 Constants and types shared by the dual-queue status-flag block.
 Assumes one system clock; port clocks arrive as one-cycle enables.
*/
package sdcf_pkg;
    localparam int DATA_W = 36;                 // Word width
    localparam int ADDR_W = 8;                  // Address width of one queue
    localparam int PTR_W  = 9;                  // Pointer width, one wrap bit
    localparam int OFS_W  = 8;                  // Offset register width

    localparam logic [PTR_W-1:0] DEPTH_WORDS = 9'h100;  // 256 words per queue

    // Flag-select preset codes and values
    localparam logic [1:0] FS_PROGRAM = 2'h0;
    localparam logic [1:0] FS_PRE8    = 2'h1;
    localparam logic [1:0] FS_PRE16   = 2'h2;
    localparam logic [1:0] FS_PRE64   = 2'h3;
    localparam logic [OFS_W-1:0] OFS_PRE8    = 8'h08;
    localparam logic [OFS_W-1:0] OFS_PRE16   = 8'h10;
    localparam logic [OFS_W-1:0] OFS_PRE64   = 8'h40;
    localparam logic [OFS_W-1:0] OFS_PROG_RST = 8'h01;  // Before programming

    // Offset programming order on port A
    localparam logic [1:0] SEL_AB_FULL  = 2'h0;
    localparam logic [1:0] SEL_AB_EMPTY = 2'h1;
    localparam logic [1:0] SEL_BA_FULL  = 2'h2;
    localparam logic [1:0] SEL_BA_EMPTY = 2'h3;

    // Queue index: 0 carries A to B, 1 carries B to A
    localparam int Q_AB = 0;
    localparam int Q_BA = 1;

    typedef logic [PTR_W-1:0] sdcf_ptr_t;
endpackage

// ---- tb/sdcf_port_model.sv ----
/*
 Far-side port agents: free-running port clocks seen as one-cycle ticks.
 Assumes the bench samples ticks on the rising edge of clk.
*/
`timescale 1ns/100ps
module sdcf_port_model #(
    parameter int A_DIV = 2,
    parameter int B_DIV = 3
) (
    input  wire logic clk,
    output logic      tick_a,
    output logic      tick_b
);
    int cnt_a = 0;
    int cnt_b = 0;

    // Ticks stay quiet until the first falling edge
    initial begin
        tick_a = 1'h0;
        tick_b = 1'h0;
    end

    // Unequal rates so the two sides drift against each other
    always @(negedge clk) begin
        cnt_a = (cnt_a + 1) % A_DIV;
        cnt_b = (cnt_b + 1) % B_DIV;
        tick_a <= (cnt_a == 0);
        tick_b <= (cnt_b == 0);
    end
endmodule // sdcf_port_model

// ---- tb/tb_dual_clock_fifo_status_flags.sv ----
/*
 Self-checking bench for the dual-queue status flags.
 Assumes the port model supplies free-running port ticks.
*/
`timescale 1ns/100ps
module tb_dual_clock_fifo_status_flags;
    import sdcf_pkg::*;
    logic        clk = 1'h0;
    logic        rst = 1'h1;
    logic [1:0]  fs = FS_PRE16;
    logic [1:0]  we = 2'h0;
    logic [1:0]  re = 2'h0;
    logic [71:0] wd = 72'h0;
    logic        ofs_we = 1'h0;
    logic [1:0]  ofs_sel = 2'h0;
    logic [7:0]  ofs_d = 8'h00;
    logic [31:0] seed = 32'h466e;
    logic [1:0]  took;
    logic [1:0]  was;
    logic [35:0] expq[2][$];
    int          num_errors = 0;
    int          samples_checked = 0;
    wire         ta;
    wire         tb;
    wire  [71:0] rdat;
    wire  [1:0]  ir, afn, orr, aen;
    wire  [1:0]  tkw = {tb, ta};
    wire  [1:0]  tkr = {ta, tb};

    sdcf_port_model #(.A_DIV(2), .B_DIV(3)) sdcf_port_model_i (.clk(clk), .tick_a(ta), .tick_b(tb));

    // Index 0 is the A to B queue, index 1 the B to A queue
    sdcf_flags sdcf_flags_i (
        .clk(clk), .rst(rst), .port_a_clock(ta), .port_b_clock(tb), .flag_select(fs),
        .ab_wr_en(we[0]), .ab_wr_data(wd[35:0]), .ab_rd_en(re[0]), .ab_rd_data(rdat[35:0]),
        .ba_wr_en(we[1]), .ba_wr_data(wd[71:36]), .ba_rd_en(re[1]), .ba_rd_data(rdat[71:36]),
        .ofs_wr_en(ofs_we), .ofs_sel(ofs_sel), .ofs_data(ofs_d),
        .port_a_in_ready(ir[0]), .port_a_almost_full_n(afn[0]),
        .port_a_out_ready(orr[1]), .port_a_almost_empty_n(aen[1]),
        .port_b_in_ready(ir[1]), .port_b_almost_full_n(afn[1]),
        .port_b_out_ready(orr[0]), .port_b_almost_empty_n(aen[0])
    );

    // Free-running system clock
    initial begin
        forever #12.5 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic got, input logic exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %0t %s", $time, m);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Wait for a writer or reader tick; strobes drop at each falling edge
    task automatic tick(input int q, input bit w);
        for (int i = 0; i < 20; i++) begin
            @(negedge clk);
            we = 2'h0;
            re = 2'h0;
            ofs_we = 1'h0;
            #1;
            if (w ? tkw[q] : tkr[q]) return;
        end
        $display("unexpected %0t wait for port tick ran out", $time);
        num_errors++;
        tally_and_finish();
    endtask

    task automatic ticks(input int q, input bit w, input int n);
        repeat (n) begin
            tick(q, w);
            @(posedge clk);
        end
        #1;
    endtask

    // Flags only move on edges, so in_ready before the edge decides acceptance
    task automatic put(input int q, output bit ok);
        logic [35:0] d;
        tick(q, 1'h1);
        d = {4'(rnd()), rnd()};
        ok = ir[q];
        we[q] = 1'h1;
        wd[q*36 +: 36] = d;
        if (ok) expq[q].push_back(d);
        @(posedge clk);
    endtask

    task automatic get(input int q);
        tick(q, 1'h0);
        re[q] = 1'h1;
        @(posedge clk);
        #1;
    endtask

    // Let both synchronisers settle, then compare levels
    task automatic lv(input int q, input int m, input int x, input int y);
        ticks(q, 1'h0, 4);
        ticks(q, 1'h1, 3);
        chk(ir[q], m < 256, "in ready level");
        chk(afn[q], m < 256 - y, "almost full level");
        chk(aen[q], m > x, "almost empty level");
    endtask

    // Each new word in an output register takes the oldest note
    always @(posedge clk) begin
        took = tkr & re & orr;
        was = orr;
        #1;
        for (int q = 0; q < 2; q++) begin
            if (orr[q] === 1'h1 && (!was[q] || took[q])) begin
                chk(expq[q].size() > 0 && rdat[q*36 +: 36] === expq[q].pop_front(), 1'h1, "data");
            end
        end
    end

    // Main sequence
    initial begin
        bit ok;
        int n;
        int x;
        int y;
        repeat (8) @(negedge clk);
        rst = 1'h0;
        for (int q = 0; q < 2; q++) begin
            chk(orr[q], 1'h0, "ready after reset");
            put(q, ok);
            ticks(q, 1'h0, 2);
            chk(orr[q], 1'h0, "word too early");
            ticks(q, 1'h0, 1);
            chk(orr[q], 1'h1, "word too late");
            lv(q, 0, 16, 16);
        end
        for (int q = 0; q < 2; q++) begin
            x = 16;
            y = 16;
            if (q == 1) begin
                x = 1 + rnd() % 252;
                y = 1 + rnd() % 252;
                for (int s = 0; s < 4; s++) begin
                    tick(0, 1'h1);
                    ofs_we = 1'h1;
                    ofs_sel = s[1:0];
                    ofs_d = s == SEL_BA_FULL ? y[7:0] : s == SEL_BA_EMPTY ? x[7:0] : 8'h10;
                    @(posedge clk);
                end
            end
            n = 0;
            // Fill until refused, checking the level bands on the way
            do begin
                put(q, ok);
                n += int'(ok);
                if (ok && (n == x || n == x + 1 || n == 255 - y || n == 256 - y)) lv(q, n, x, y);
            end while (ok && n < 300);
            chk(n == 256, 1'h1, "fill count");
            lv(q, 256, x, y);
            get(q);
            ticks(q, 1'h1, 1);
            chk(ir[q], 1'h0, "in ready too soon");
            ticks(q, 1'h1, 1);
            chk(ir[q], 1'h1, "in ready too late");
            for (int i = 0; i < 300 && orr[q]; i++) get(q);
            get(q);
            lv(q, 0, x, y);
            chk(orr[q], 1'h0, "not drained");
            chk(expq[q].size() == 0, 1'h1, "words lost");
        end
        tally_and_finish();
    end
endmodule // tb_dual_clock_fifo_status_flags
